/* File: include/pbwl_cfg.svh */
// Register map, field positions, reset values and timing counts of the
// password-gated write lock. Included by every module; the package does not include it.
`ifndef PBWL_CFG_SVH
`define PBWL_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PBWL_ADDR_W 6
`define PBWL_OFF_KEY 6'h00
`define PBWL_OFF_CLKCR 6'h04
`define PBWL_OFF_GSET 6'h08
`define PBWL_OFF_GCLR 6'h0c
`define PBWL_OFF_GSTAT 6'h10
`define PBWL_OFF_ADCA 6'h14
`define PBWL_OFF_ADCB 6'h18
`define PBWL_OFF_IRQST 6'h1c
`define PBWL_OFF_IRQCLR 6'h20
`define PBWL_OFF_IRQEN 6'h24

// ----------------------------------------------------------------
// Key control fields
// ----------------------------------------------------------------
`define PBWL_MODE_LSB 0
`define PBWL_MODE_MSB 1
`define PBWL_LOCK_BIT 2
`define PBWL_KEY_LSB 3
`define PBWL_KEY_MSB 7
`define PBWL_MODE_RST 2'h3

// ----------------------------------------------------------------
// Clock control: divider and select fields are the guarded part
// ----------------------------------------------------------------
`define PBWL_CLKCR_GUARD 32'h000fffff
`define PBWL_CLKCR_RST 32'h00000000
`define PBWL_GATE_RST 32'h00000000
`define PBWL_ADC_RST 32'h00000000

// ----------------------------------------------------------------
// Event bits
// ----------------------------------------------------------------
`define PBWL_IRQ_W 3
`define PBWL_EV_DROP 0
`define PBWL_EV_FAULT 1
`define PBWL_EV_EXPIRE 2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PBWL_WIN_CYC 32

`endif

/* File: include/pbwl_pkg.sv */
// Types shared by the write lock modules.
// Assumes pbwl_cfg.svh is on the include path.
package pbwl_pkg;

  // Key codes recognised in the key field
  typedef enum logic [4:0] {
    KEY_MODE_LOAD = 5'h18,
    KEY_OPEN = 5'h13,
    KEY_CLOSE = 5'h15
  } pbwl_key_t;

  // Bus handshake states
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } pbwl_bus_st_t;

endpackage

/* File: rtl/pbwl_field_reg.sv */
// Masked-write register used for the plain and guarded registers.
// Assumes the caller folds lock state into the write enable or the write mask.
`timescale 1ns/10ps
`include "pbwl_cfg.svh"

module pbwl_field_reg #(
  parameter int unsigned W = 32,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Write port
  input wire logic we_i,
  input wire logic [W-1:0] mask_i,
  input wire logic [W-1:0] wdata_i,
  // Stored value
  output logic [W-1:0] q_o
);

  generate
    if (W < 1) begin : g_chk
      $error("pbwl_field_reg: width must be at least 1");
    end
  endgenerate

  logic [W-1:0] q_d;

  assign q_d = (q_o & ~mask_i) | (wdata_i & mask_i);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q_o <= RST;
    end else if (we_i) begin
      q_o <= q_d;
    end
  end

endmodule // pbwl_field_reg

/* File: rtl/pbwl_top.sv */
// Password-gated write lock with its guarded clock and ADC guard registers.
// Assumes an Avalon-MM master on the main clock and a synchronous world.
//
// What this block does
// - Scheme enabled: key 10011 opens writes to all guarded fields.
// - Scheme enabled: key 10101 closes writes to guarded fields at once.
// - Scheme field loads the written value only with key 11000.
// - Open or close key writes leave the scheme field untouched.
// - Direct writes to the scheme field are refused.
// - An open window shuts by itself after 32 clock cycles.
// - Open key during a window restarts a full 32-cycle count.
// - Scheme field 00 disables the lock; guarded writes always land.
// - Scheme field resets to 11, lock enabled.
// - Scheme values 01 and 10 behave as 11.
// - Status bit 2 reads 0 when writable, 1 when locked.
// - Only the three defined keys act; other key values do nothing.
// - Guarded: clock divider/select, gate set/clear, both ADC guards.
// - Locked writes to clock and gate registers drop with no error.
// - Locked writes to either ADC guard raise a hard fault.
`timescale 1ns/10ps
`include "pbwl_cfg.svh"

module pbwl_top #(
  parameter int unsigned WIN_CYCLES = `PBWL_WIN_CYC,
  parameter int unsigned DW = 32
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Avalon-MM slave
  input wire logic [`PBWL_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DW-1:0] avs_writedata_i,
  input wire logic [DW/8-1:0] avs_byteenable_i,
  output logic [DW-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Guarded system controls
  output logic [DW-1:0] clk_ctrl_o,
  output logic [DW-1:0] clk_gate_o,
  output logic [DW-1:0] adc_guard_a_o,
  output logic [DW-1:0] adc_guard_b_o,
  // Lock status and events
  output logic lock_state_o,
  output logic hard_fault_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  generate
    if (DW != 32) begin : g_dw_chk
      $error("pbwl_top: register map is laid out for 32-bit data");
    end
    if (WIN_CYCLES < 1) begin : g_win_chk
      $error("pbwl_top: window must last at least one cycle");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Widens byte enables into a bit mask
  function automatic logic [DW-1:0] be_mask(
    input logic [DW/8-1:0] be
  );
    logic [DW-1:0] m;
    m = '0;
    for (int i = 0; i < DW / 8; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // Address match against one register offset
  function automatic logic hit(
    input logic [`PBWL_ADDR_W-1:0] a,
    input logic [`PBWL_ADDR_W-1:0] off
  );
    return a == off;
  endfunction

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // Every access answers in fixed time: request seen, then one
  // cycle with waitrequest low, at whose end the write lands.
  pbwl_pkg::pbwl_bus_st_t bus_st_q;
  pbwl_pkg::pbwl_bus_st_t bus_st_d;
  logic req;
  logic wr_go;
  logic [DW-1:0] wmask;

  assign req = avs_read_i | avs_write_i;
  assign bus_st_d = (bus_st_q == pbwl_pkg::BUS_IDLE && req) ?
                    pbwl_pkg::BUS_ACK : pbwl_pkg::BUS_IDLE;
  assign wr_go = (bus_st_q == pbwl_pkg::BUS_ACK) && avs_write_i;
  assign wmask = be_mask(avs_byteenable_i);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_st_q <= pbwl_pkg::BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
    end else begin
      bus_st_q <= bus_st_d;
      avs_waitrequest_o <= (bus_st_d != pbwl_pkg::BUS_ACK);
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic sel_key;
  logic sel_clkcr;
  logic sel_gset;
  logic sel_gclr;
  logic sel_gstat;
  logic sel_adca;
  logic sel_adcb;
  logic sel_irqst;
  logic sel_irqclr;
  logic sel_irqen;

  assign sel_key = hit(avs_address_i, `PBWL_OFF_KEY);
  assign sel_clkcr = hit(avs_address_i, `PBWL_OFF_CLKCR);
  assign sel_gset = hit(avs_address_i, `PBWL_OFF_GSET);
  assign sel_gclr = hit(avs_address_i, `PBWL_OFF_GCLR);
  assign sel_gstat = hit(avs_address_i, `PBWL_OFF_GSTAT);
  assign sel_adca = hit(avs_address_i, `PBWL_OFF_ADCA);
  assign sel_adcb = hit(avs_address_i, `PBWL_OFF_ADCB);
  assign sel_irqst = hit(avs_address_i, `PBWL_OFF_IRQST);
  assign sel_irqclr = hit(avs_address_i, `PBWL_OFF_IRQCLR);
  assign sel_irqen = hit(avs_address_i, `PBWL_OFF_IRQEN);

  // ----------------------------------------------------------------
  // Key field and scheme control
  // ----------------------------------------------------------------
  logic [1:0] mode_q;
  logic [4:0] key_in;
  logic key_wr;
  logic key_open;
  logic key_close;
  logic key_load;
  logic scheme_on;
  logic win_open;
  logic win_expire;
  logic locked;

  // The key lives in the low byte; without that lane nothing acts
  assign key_wr = wr_go && sel_key && avs_byteenable_i[0];
  assign key_in = avs_writedata_i[`PBWL_KEY_MSB:`PBWL_KEY_LSB];
  assign scheme_on = (mode_q != 2'h0);
  assign key_open = key_wr && scheme_on &&
                    key_in == pbwl_pkg::KEY_OPEN;
  assign key_close = key_wr && scheme_on &&
                     key_in == pbwl_pkg::KEY_CLOSE;
  assign key_load = key_wr &&
                    key_in == pbwl_pkg::KEY_MODE_LOAD;

  // Only the load key reaches the scheme field; open, close and
  // every other key value leave it alone
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_q <= `PBWL_MODE_RST;
    end else if (key_load) begin
      mode_q <= avs_writedata_i[`PBWL_MODE_MSB:`PBWL_MODE_LSB];
    end
  end

  pbwl_window_timer #(
    .CYCLES(WIN_CYCLES)
  ) u_window (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .open_key_i(key_open),
    .close_key_i(key_close),
    .open_o(win_open),
    .expire_o(win_expire)
  );

  // Writable whenever the scheme is off or a window is open
  assign locked = scheme_on && !win_open;

  // ----------------------------------------------------------------
  // Guarded clock control
  // ----------------------------------------------------------------
  logic clk_we;
  logic [DW-1:0] clk_mask;

  // Unguarded bits always land; guarded ones only while unlocked
  assign clk_we = wr_go && sel_clkcr;
  assign clk_mask = wmask & (locked ?
                    ~`PBWL_CLKCR_GUARD : '1);

  pbwl_field_reg #(
    .W(DW),
    .RST(`PBWL_CLKCR_RST)
  ) u_clkcr (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .we_i(clk_we),
    .mask_i(clk_mask),
    .wdata_i(avs_writedata_i),
    .q_o(clk_ctrl_o)
  );

  // ----------------------------------------------------------------
  // Guarded clock gates
  // ----------------------------------------------------------------
  logic gate_set_ok;
  logic gate_clr_ok;
  logic [DW-1:0] gate_set;
  logic [DW-1:0] gate_clr;
  localparam logic [DW-1:0] GATE_RST = `PBWL_GATE_RST;

  assign gate_set_ok = wr_go && sel_gset && !locked;
  assign gate_clr_ok = wr_go && sel_gclr && !locked;
  assign gate_set = {DW{gate_set_ok}} & wmask & avs_writedata_i;
  assign gate_clr = {DW{gate_clr_ok}} & wmask & avs_writedata_i;

  genvar gi;
  generate
    for (gi = 0; gi < DW; gi++) begin : g_gate
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          clk_gate_o[gi] <= GATE_RST[gi];
        end else if (gate_set[gi]) begin
          clk_gate_o[gi] <= 1'b1;
        end else if (gate_clr[gi]) begin
          clk_gate_o[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Guarded ADC access registers
  // ----------------------------------------------------------------
  logic adca_we;
  logic adcb_we;
  logic adc_fault;

  assign adca_we = wr_go && sel_adca && !locked;
  assign adcb_we = wr_go && sel_adcb && !locked;
  // A locked write is not just dropped here: it faults
  assign adc_fault = wr_go && (sel_adca || sel_adcb) && locked;

  pbwl_field_reg #(
    .W(DW),
    .RST(`PBWL_ADC_RST)
  ) u_adca (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .we_i(adca_we),
    .mask_i(wmask),
    .wdata_i(avs_writedata_i),
    .q_o(adc_guard_a_o)
  );

  pbwl_field_reg #(
    .W(DW),
    .RST(`PBWL_ADC_RST)
  ) u_adcb (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .we_i(adcb_we),
    .mask_i(wmask),
    .wdata_i(avs_writedata_i),
    .q_o(adc_guard_b_o)
  );

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  logic [`PBWL_IRQ_W-1:0] irq_st_q;
  logic [`PBWL_IRQ_W-1:0] irq_st_d;
  logic [`PBWL_IRQ_W-1:0] irq_en;
  logic [`PBWL_IRQ_W-1:0] irq_set;
  logic [`PBWL_IRQ_W-1:0] irq_clr;
  logic drop_ev;

  // A dropped guarded write is invisible on the bus; the sticky
  // bit gives software a second way to notice it
  assign drop_ev = wr_go && locked &&
                   (sel_gset || sel_gclr ||
                    (sel_clkcr &&
                     |(wmask & `PBWL_CLKCR_GUARD)));
  assign irq_set[`PBWL_EV_DROP] = drop_ev;
  assign irq_set[`PBWL_EV_FAULT] = adc_fault;
  assign irq_set[`PBWL_EV_EXPIRE] = win_expire;
  assign irq_clr = (wr_go && sel_irqclr) ?
                   avs_writedata_i[`PBWL_IRQ_W-1:0] : '0;
  // Set wins over a clear landing in the same cycle
  assign irq_st_d = (irq_st_q & ~irq_clr) | irq_set;

  pbwl_field_reg #(
    .W(`PBWL_IRQ_W),
    .RST('0)
  ) u_irqen (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .we_i(wr_go && sel_irqen),
    .mask_i(wmask[`PBWL_IRQ_W-1:0]),
    .wdata_i(avs_writedata_i[`PBWL_IRQ_W-1:0]),
    .q_o(irq_en)
  );

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_st_q <= '0;
      irq_o <= 1'b0;
      hard_fault_o <= 1'b0;
      lock_state_o <= 1'b1;
    end else begin
      irq_st_q <= irq_st_d;
      irq_o <= |(irq_st_d & irq_en);
      hard_fault_o <= adc_fault;
      lock_state_o <= locked;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [DW-1:0] key_rd;
  logic [DW-1:0] rd_mux;

  // Key field is write-only and upper bits reserved: both read 0
  assign key_rd = {{(DW-3){1'b0}}, locked, mode_q};

  // Unmapped offsets read zero and ignore writes
  assign rd_mux =
    sel_key ? key_rd :
    sel_clkcr ? clk_ctrl_o :
    sel_gstat ? clk_gate_o :
    sel_adca ? adc_guard_a_o :
    sel_adcb ? adc_guard_b_o :
    sel_irqst ? {{(DW-`PBWL_IRQ_W){1'b0}}, irq_st_q} :
    sel_irqen ? {{(DW-`PBWL_IRQ_W){1'b0}}, irq_en} :
    '0;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avs_readdata_o <= '0;
    end else if (bus_st_d == pbwl_pkg::BUS_ACK) begin
      avs_readdata_o <= rd_mux;
    end
  end

endmodule // pbwl_top

/* File: rtl/pbwl_window_timer.sv */
// Open-window timer: open key (re)loads the full count, close key ends it.
// Assumes open and close keys are one-cycle pulses, never both at once.
`timescale 1ns/10ps
`include "pbwl_cfg.svh"

module pbwl_window_timer #(
  parameter int unsigned CYCLES = `PBWL_WIN_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Key events
  input wire logic open_key_i,
  input wire logic close_key_i,
  // Window state
  output logic open_o,
  output logic expire_o
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  generate
    if (CYCLES < 1) begin : g_chk
      $error("pbwl_window_timer: window must last at least one cycle");
    end
  endgenerate

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic run_out;

  // Close beats a reload so a late close cannot be undone
  assign cnt_d = close_key_i ? '0 :
                 open_key_i ? CYCLES[CW-1:0] :
                 (cnt_q != '0) ? cnt_q - 1'b1 : '0;
  assign run_out = (cnt_q == {{(CW-1){1'b0}}, 1'b1}) &&
                   !open_key_i && !close_key_i;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
      open_o <= 1'b0;
      expire_o <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      open_o <= (cnt_d != '0);
      expire_o <= run_out;
    end
  end

endmodule // pbwl_window_timer

/* File: test/pbwl_monitor.sv */
// Checker for the write lock: window, fault pulse and read-back values.
// Assumes it is bound to pbwl_top and sees only that module's ports.
`timescale 1ns/10ps
`include "pbwl_cfg.svh"
module pbwl_monitor #(
  parameter int unsigned WIN_CYCLES = 32,
  parameter int unsigned DW = 32
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Bus
  input wire logic [`PBWL_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DW-1:0] avs_writedata_i,
  input wire logic [DW/8-1:0] avs_byteenable_i,
  input wire logic [DW-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Status
  input wire logic lock_state_o,
  input wire logic hard_fault_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  logic [1:0] mode_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic wr_land, rd_land, key_land, adc_land, on, open_l, close_l, mode_l;
  logic [4:0] kval;
  assign wr_land = avs_write_i && !avs_waitrequest_o;
  assign rd_land = avs_read_i && !avs_waitrequest_o;
  assign kval = avs_writedata_i[7:3];
  assign key_land = wr_land && avs_address_i == `PBWL_OFF_KEY
    && avs_byteenable_i[0];
  assign adc_land = wr_land && (avs_address_i == `PBWL_OFF_ADCA
    || avs_address_i == `PBWL_OFF_ADCB);
  assign on = mode_q != 2'h0;
  assign open_l = key_land && kval == pbwl_pkg::KEY_OPEN && on;
  assign close_l = key_land && kval == pbwl_pkg::KEY_CLOSE && on;
  assign mode_l = key_land && kval == pbwl_pkg::KEY_MODE_LOAD;
  // Window ages down; any mode load clears it so no check is claimed then
  assign cnt_d = open_l ? 8'(WIN_CYCLES) : (close_l || mode_l) ? 8'h00 :
    (cnt_q != 8'h00) ? cnt_q - 8'h01 : 8'h00;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_q <= `PBWL_MODE_RST;
      cnt_q <= 8'h00;
    end else begin
      mode_q <= mode_l ? avs_writedata_i[1:0] : mode_q;
      cnt_q <= cnt_d;
    end
  end
  sequence s_last;
    cnt_q == 8'h01 && on && !key_land;
  endsequence
  sequence s_quiet;
    s_last ##1 !key_land;
  endsequence
  a_window_open: assert property (
    cnt_q != 8'h00 && cnt_q != 8'(WIN_CYCLES) |-> !lock_state_o)
    else $error("guarded writes blocked inside open window");
  a_window_expire: assert property (s_quiet |=> lock_state_o)
    else $error("window did not close after its count");
  a_close_locks: assert property (close_l |-> ##2 lock_state_o)
    else $error("close key did not lock");
  a_mode_zero: assert property (
    mode_q == 2'h0 && $past(mode_q) == 2'h0 |-> !lock_state_o)
    else $error("lock shown with scheme disabled");
  a_fault_single: assert property (hard_fault_o |=> !hard_fault_o)
    else $error("hard fault longer than one cycle");
  a_fault_cause: assert property (
    hard_fault_o |-> $past(adc_land) || $past(adc_land, 2))
    else $error("hard fault without ADC guard write");
  a_key_reads: assert property (
    rd_land && avs_address_i == `PBWL_OFF_KEY
    |-> avs_readdata_o[31:3] == 29'h0)
    else $error("key or reserved bits read nonzero");
  a_wo_reads: assert property (
    rd_land && (avs_address_i == `PBWL_OFF_GSET
    || avs_address_i == `PBWL_OFF_GCLR) |-> avs_readdata_o == '0)
    else $error("write-only register read nonzero");
endmodule // pbwl_monitor

bind pbwl_top pbwl_monitor #(.WIN_CYCLES(WIN_CYCLES), .DW(DW)) u_mon (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .lock_state_o(lock_state_o), .hard_fault_o(hard_fault_o));

/* File: test/tb.sv */
// Self-checking bench for the write lock: row table, then edge cases.
// Assumes design files and the include path are compiled before it.
`timescale 1ns/10ps
`include "pbwl_cfg.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
  // Short window keeps the run brief; expectations use the same value
  localparam int unsigned WIN = 8;
  logic clock_i, rst_b_i, rd, wr, wreq, lock, hf, irq;
  logic [5:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rx, rdo, clk_ctrl, gate, adc_a, adc_b;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int hf_cnt = 0;
  logic [5:0] wa[6] = '{`PBWL_OFF_IRQEN, `PBWL_OFF_CLKCR, `PBWL_OFF_GSET,
    6'h3c, `PBWL_OFF_KEY, `PBWL_OFF_GCLR};
  logic [31:0] wd[6] = '{32'h7, 32'hffffffff, 32'hffffffff, 32'hffffffff,
    32'hf8, 32'hffffffff};
  logic [5:0] ra[6] = '{`PBWL_OFF_IRQEN, `PBWL_OFF_CLKCR, `PBWL_OFF_GSTAT,
    6'h3c, `PBWL_OFF_KEY, `PBWL_OFF_GCLR};
  logic [31:0] re[6] = '{32'h7, 32'hfff00000, 32'h0, 32'h0, 32'h7, 32'h0};

  pbwl_top #(.WIN_CYCLES(WIN), .DW(32)) u_pbwl_top (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdo), .avs_waitrequest_o(wreq),
    .clk_ctrl_o(clk_ctrl), .clk_gate_o(gate), .adc_guard_a_o(adc_a),
    .adc_guard_b_o(adc_b), .lock_state_o(lock), .hard_fault_o(hf),
    .irq_o(irq));

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // Hang guard and fault pulse counter
  always @(posedge clock_i) begin
    cyc++;
    hf_cnt += int'(hf === 1'b1);
    if (cyc == 3000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One access; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int n = 0;
    @(posedge clock_i);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    be <= b;
    do begin
      @(posedge clock_i);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    rx = rdo;
    rd <= 1'b0;
    wr <= 1'b0;
    `CHK("waitrequest", 1'b0, wreq)
    // Let this edge's register updates settle before callers compare
    @(negedge clock_i);
  endtask

  task automatic w32(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic chk_rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    `CHK("readdata", e, rx)
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  initial begin
    rst_b_i = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 6'h00;
    wdata = 32'h0;
    be = 4'hf;
    pause(4);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      w32(wa[i], wd[i]);
      chk_rd(ra[i], re[i]);
    end
    `CHK("irq", 1'b1, irq)
    w32(`PBWL_OFF_IRQCLR, 32'h7);
    pause(2);
    `CHK("irq", 1'b0, irq)
    $display("end of table");
    w32(`PBWL_OFF_ADCA, 32'h5a);
    pause(3);
    `CHK("fault", 1, hf_cnt)
    `CHK("adc_a", 32'h0, adc_a)
    `CHK("irq", 1'b1, irq)
    w32(`PBWL_OFF_KEY, 32'h98);
    w32(`PBWL_OFF_ADCA, 32'h5a);
    w32(`PBWL_OFF_GSET, 32'h5);
    pause(4);
    `CHK("adc_a", 32'h5a, adc_a)
    `CHK("gate", 32'h5, gate)
    `CHK("fault", 1, hf_cnt)
    chk_rd(`PBWL_OFF_KEY, 32'h7);
    $display("end of open");
    w32(`PBWL_OFF_KEY, 32'h9b);
    w32(`PBWL_OFF_KEY, 32'ha8);
    w32(`PBWL_OFF_CLKCR, 32'hfff000ff);
    `CHK("clk_ctrl", 32'hfff00000, clk_ctrl)
    chk_rd(`PBWL_OFF_KEY, 32'h7);
    // Clean status so only the coming expiry can show
    w32(`PBWL_OFF_IRQCLR, 32'h7);
    w32(`PBWL_OFF_KEY, 32'h98);
    w32(`PBWL_OFF_KEY, 32'h98);
    w32(`PBWL_OFF_CLKCR, 32'hfff00001);
    w32(`PBWL_OFF_CLKCR, 32'hfff00002);
    `CHK("clk_ctrl", 32'hfff00002, clk_ctrl)
    pause(WIN + 2);
    chk_rd(`PBWL_OFF_IRQST, 32'h4);
    w32(`PBWL_OFF_KEY, 32'h98);
    w32(`PBWL_OFF_CLKCR, 32'hfff00003);
    w32(`PBWL_OFF_CLKCR, 32'hfff00004);
    w32(`PBWL_OFF_CLKCR, 32'hfff00005);
    `CHK("clk_ctrl", 32'hfff00004, clk_ctrl)
    $display("end of window");
    w32(`PBWL_OFF_KEY, 32'hc0);
    chk_rd(`PBWL_OFF_KEY, 32'h0);
    w32(`PBWL_OFF_ADCB, 32'h33);
    w32(`PBWL_OFF_KEY, 32'ha8);
    w32(`PBWL_OFF_CLKCR, 32'hfff00006);
    `CHK("adc_b", 32'h33, adc_b)
    `CHK("clk_ctrl", 32'hfff00006, clk_ctrl)
    `CHK("fault", 1, hf_cnt)
    `CHK("lock", 1'b0, lock)
    w32(`PBWL_OFF_KEY, 32'hc1);
    chk_rd(`PBWL_OFF_KEY, 32'h5);
    bus(1'b1, `PBWL_OFF_KEY, 32'h98, 4'he);
    w32(`PBWL_OFF_CLKCR, 32'hfff00007);
    `CHK("clk_ctrl", 32'hfff00006, clk_ctrl)
    w32(`PBWL_OFF_KEY, 32'h98);
    w32(`PBWL_OFF_CLKCR, 32'hfff00008);
    `CHK("clk_ctrl", 32'hfff00008, clk_ctrl)
    w32(`PBWL_OFF_IRQEN, 32'h0);
    pause(2);
    `CHK("irq", 1'b0, irq)
    $display("end of modes");
    rst_b_i <= 1'b0;
    pause(2);
    `CHK("lock", 1'b1, lock)
    `CHK("clk_ctrl", 32'h0, clk_ctrl)
    rst_b_i <= 1'b1;
    chk_rd(`PBWL_OFF_KEY, 32'h7);
    $display("end of reset");
    give_verdict();
  end
endmodule // tb
